/* File: design/rfc_map.svh */
// flags register field positions, reset values and timing counts
`ifndef RFC_MAP_SVH
`define RFC_MAP_SVH
// ****************************************
// flags and control register layout
// ****************************************
`define RFC_BIT_RD_EN 0
`define RFC_BIT_WR_EN 1
`define RFC_BIT_CAL 2
`define RFC_BIT_OSCILLATOR_FAULT_FLAG 4
`define RFC_BIT_PF 5
`define RFC_BIT_AF 6
`define RFC_BIT_WDF 7
`define RFC_FLAGS_RST 8'h00
`define RFC_TIME_RST 32'h0000_0000
// ****************************************
// timing
// ****************************************
`define RFC_CLK_NS 4
`define RFC_XFER_NS 1000
`define RFC_XFER_CYC ((`RFC_XFER_NS + `RFC_CLK_NS - 1) / `RFC_CLK_NS)
`endif

/* File: design/rfc_pkg.sv */
// shared types of the rtc flags and control block
package rfc_pkg;
  // one register byte
  typedef logic [7:0] rfc_byte_t;
  // timekeeping value, seconds count
  typedef logic [31:0] rfc_time_t;
  // transfer timer states
  typedef enum logic [0:0]
  {
    RFC_IDLE = 1'b0,
    RFC_RUN = 1'b1
  } rfc_xfer_state_t;
endpackage : rfc_pkg

/* File: design/rfc_top.sv */
// rtc flags and control register with user/live clock exchange
`timescale 1ns/100ps
`include "rfc_map.svh"
module rfc_top
#(
  parameter int XFER_CYC = `RFC_XFER_CYC
)
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // flags register access from the serial host controller
  input wire logic i_flags_wr,
  input wire logic i_flags_rd,
  input wire rfc_pkg::rfc_byte_t i_flags_wdata,
  output rfc_pkg::rfc_byte_t o_flags_rdata,
  // user clock register access
  input wire logic i_user_wr,
  input wire rfc_pkg::rfc_time_t i_user_wdata,
  output rfc_pkg::rfc_time_t o_user_time,
  // timebase and events, same clock domain
  input wire logic i_rtc_tick,
  input wire logic i_wdog_evt,
  input wire logic i_alarm_evt,
  input wire logic i_pfail_evt,
  input wire logic i_osc_fault_evt,
  // status outputs
  output logic o_cal_en,
  output logic o_xfer_busy,
  output rfc_pkg::rfc_time_t o_live_time
);
  import rfc_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic rd_en; // user copy frozen
  logic wr_en; // user copy open for writes
  logic cal; // calibration output mode
  logic watchdog_expired_flag; // sticky watchdog event
  logic alarm_match_flag; // sticky alarm event
  logic power_fail_flag; // sticky power fail
  logic oscillator_fault_flag; // sticky, cleared by writing zero
  rfc_time_t live; // running timekeeper
  rfc_time_t user; // user-visible holding copy
  rfc_xfer_if xf ();

  // ****************************************
  // decode
  // ****************************************
  wire logic wr_clear; // write bit 1 to 0: start transfer
  wire logic copy_live; // holding copy follows the counter
  wire rfc_byte_t flags_now; // register image
  wire logic rd_clr; // read clears event flags except osc fault

  assign wr_clear = i_flags_wr && wr_en && !i_flags_wdata[`RFC_BIT_WR_EN];
  // copy stops while read bit set
  // frozen copy hides counter advance
  // done cycle excluded: live and copy would swap values there
  assign copy_live = !rd_en && !wr_en && !xf.busy && !xf.done;
  assign rd_clr = i_flags_rd;
  assign flags_now = {watchdog_expired_flag, alarm_match_flag,
                      power_fail_flag, oscillator_fault_flag,
                      1'b0, cal, wr_en, rd_en};
  assign xf.start = wr_clear;

  // control bits
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rd_en <= 1'b0;
      wr_en <= 1'b0;
      cal <= 1'b0;
    end
    else if (i_flags_wr)
    begin
      rd_en <= i_flags_wdata[`RFC_BIT_RD_EN];
      wr_en <= i_flags_wdata[`RFC_BIT_WR_EN];
      cal <= i_flags_wdata[`RFC_BIT_CAL];
    end
  end

  // event flags, the set wins over a clearing read
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      watchdog_expired_flag <= 1'b0;
      alarm_match_flag <= 1'b0;
      power_fail_flag <= 1'b0;
      oscillator_fault_flag <= 1'b0;
    end
    else
    begin
      // set by event, cleared by read
      watchdog_expired_flag <= i_wdog_evt | (watchdog_expired_flag & !rd_clr);
      alarm_match_flag <= i_alarm_evt | (alarm_match_flag & !rd_clr);
      power_fail_flag <= i_pfail_evt | (power_fail_flag & !rd_clr);
      // oscillator fault only clears by writing zero
      oscillator_fault_flag <= i_osc_fault_evt | (oscillator_fault_flag &
        !(i_flags_wr && !i_flags_wdata[`RFC_BIT_OSCILLATOR_FAULT_FLAG]));
    end
  end

  // running counter, loaded when a transfer completes
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      live <= `RFC_TIME_RST;
    else if (xf.done)
      // user value lands after transfer time
      live <= user;
    else if (i_rtc_tick)
      live <= live + 32'h0000_0001;
  end

  // holding copy seen by the host
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      user <= `RFC_TIME_RST;
    else if (wr_en && i_user_wr)
      user <= i_user_wdata;
    else if (copy_live)
      user <= live;
  end

  // registered outputs; read data captured on a read
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_flags_rdata <= `RFC_FLAGS_RST;
      o_user_time <= `RFC_TIME_RST;
      o_live_time <= `RFC_TIME_RST;
      o_cal_en <= 1'b0;
      o_xfer_busy <= 1'b0;
    end
    else
    begin
      if (i_flags_rd)
        o_flags_rdata <= flags_now;
      o_user_time <= user;
      o_live_time <= live;
      o_cal_en <= cal;
      o_xfer_busy <= xf.busy || wr_clear;
    end
  end

  // ****************************************
  // transfer timer
  // ****************************************
  rfc_xfer #(.XFER_CYC(XFER_CYC)) u_xfer
  (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .xf(xf)
  );

  // ****************************************
  // checks
  // ****************************************
  // frozen copy never moves without a write
  property p_freeze;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (rd_en && !wr_en) |=> $stable(user);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("user copy moved while frozen");

  // a tick under freeze is not seen at the output
  property p_hide;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (rd_en && !wr_en && i_rtc_tick && !i_flags_wr) ##1 rd_en
        |=> $stable(o_user_time);
  endproperty
  a_hide: assert property (p_hide)
    else $error("counter advance visible under freeze");

  // released copy tracks the counter one cycle later
  property p_resume;
    @(posedge i_mclk) disable iff (!i_arst_n)
      copy_live |=> (user == $past(live));
  endproperty
  a_resume: assert property (p_resume)
    else $error("user copy not following counter");

  // read bit alone takes effect
  property p_rd_alone;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (i_flags_wr && i_flags_wdata == 8'h01) |=> (rd_en && !wr_en);
  endproperty
  a_rd_alone: assert property (p_rd_alone)
    else $error("read bit did not set without write bit");

  // write clear raises busy at the output next cycle
  property p_wr_busy;
    @(posedge i_mclk) disable iff (!i_arst_n)
      wr_clear |=> o_xfer_busy ##1 xf.busy;
  endproperty
  a_wr_busy: assert property (p_wr_busy)
    else $error("transfer not started by write bit clear");

  // reset leaves both control bits low
  property p_rst;
    @(posedge i_mclk) $rose(i_arst_n) |-> (!rd_en && !wr_en);
  endproperty
  a_rst: assert property (p_rst)
    else $error("control bits not zero after reset");

  // read clears watchdog flag unless a new event
  property p_rdclr;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (i_flags_rd && !i_wdog_evt) ##1 i_wdog_evt |-> watchdog_expired_flag
        == 1'b0 ##1 watchdog_expired_flag;
  endproperty
  a_rdclr: assert property (p_rdclr)
    else $error("watchdog flag read-clear or set wrong");
endmodule : rfc_top

/* File: design/rfc_xfer.sv */
// transfer timer: paces user-to-counter copy over the transfer time
`timescale 1ns/100ps
`include "rfc_map.svh"
module rfc_xfer
#(
  parameter int XFER_CYC = `RFC_XFER_CYC
)
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // handshake with flags logic
  rfc_xfer_if.tmr xf
);
  import rfc_pkg::*;
  // done is registered, so it shows one cycle after the last busy cycle
  localparam int CYC = XFER_CYC + 1;
  localparam logic [15:0] LAST = 16'(XFER_CYC - 1);

  rfc_xfer_state_t state; // timer state
  rfc_xfer_state_t next_state; // next timer state
  logic [15:0] cnt; // cycles spent in the transfer
  logic at_end; // final cycle of the transfer

  assign at_end = (state == RFC_RUN) && (cnt == LAST);

  // ****************************************
  // state decode
  // ****************************************
  always_comb
  begin
    case (state)
      RFC_IDLE: next_state = xf.start ? RFC_RUN : RFC_IDLE;
      RFC_RUN: next_state = at_end ? RFC_IDLE : RFC_RUN;
      default: next_state = RFC_IDLE;
    endcase
  end

  // state, count and done pulse
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state <= RFC_IDLE;
      cnt <= 16'h0000;
      xf.done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      // restart count each time a transfer opens
      cnt <= (state == RFC_RUN) ? cnt + 16'h0001 : 16'h0000;
      xf.done <= at_end;
    end
  end

  assign xf.busy = (state == RFC_RUN);

  property p_xfer_len;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (xf.start && state == RFC_IDLE) |-> ##[CYC:CYC] xf.done;
  endproperty
  a_xfer_len: assert property (p_xfer_len)
    else $error("transfer did not end after the transfer time");
endmodule : rfc_xfer

/* File: design/rfc_xfer_if.sv */
// handshake between flags logic and the transfer timer
`timescale 1ns/100ps
interface rfc_xfer_if;
  logic start; // one-cycle request to begin a transfer
  logic busy; // transfer in progress
  logic done; // one-cycle pulse at transfer end
  modport ctl (output start, input busy, input done);
  modport tmr (input start, output busy, output done);
endinterface : rfc_xfer_if

/* File: verification/rfc_host_model.sv */
// host controller model driving the flags register strobes
`timescale 1ns/100ps
module rfc_host_model
(
  // clock
  input wire logic i_mclk,
  // flags register access
  output logic o_wr,
  output logic o_rd,
  output rfc_pkg::rfc_byte_t o_wdata,
  input wire rfc_pkg::rfc_byte_t i_rdata
);
  import rfc_pkg::*;
  // idle strobes from time zero
  initial
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end
  // write needs no prior step
  // one-cycle write; data inverted once released, so stale data
  // never passes for valid
  task automatic put(input rfc_byte_t v);
    @(negedge i_mclk);
    o_wr = 1'b1;
    o_wdata = v;
    @(negedge i_mclk);
    o_wr = 1'b0;
    o_wdata = ~v;
  endtask : put
  // one-cycle read; answer stands until the next read
  task automatic get(output rfc_byte_t v);
    @(negedge i_mclk);
    o_rd = 1'b1;
    @(negedge i_mclk);
    o_rd = 1'b0;
    @(negedge i_mclk);
    v = i_rdata;
  endtask : get
endmodule : rfc_host_model

/* File: verification/test_rfc_top.sv */
// self-checking bench of the flags and control block
`timescale 1ns/100ps
module test_rfc_top;
  import rfc_pkg::*;
  // short transfer count keeps the run brief
  localparam int XC = 4;
  logic i_mclk, i_arst_n, fwr, frd, uwr, tick, cal, busy;
  logic [3:0] ev; // watchdog, alarm, power fail, osc fault
  logic [3:0] s, a, b; // expected sticky flags, events in and after read cycles
  rfc_byte_t fwd, frdata, rb;
  rfc_time_t uwd, utime, ltime, cnt, snap, v;
  int miscompares, checks_done, seed, n;
  rfc_top #(.XFER_CYC(XC)) dut
  (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_flags_wr(fwr),
    .i_flags_rd(frd), .i_flags_wdata(fwd), .o_flags_rdata(frdata),
    .i_user_wr(uwr), .i_user_wdata(uwd), .o_user_time(utime),
    .i_rtc_tick(tick), .i_wdog_evt(ev[3]), .i_alarm_evt(ev[2]),
    .i_pfail_evt(ev[1]), .i_osc_fault_evt(ev[0]), .o_cal_en(cal),
    .o_xfer_busy(busy), .o_live_time(ltime)
  );
  rfc_host_model host
  (
    .i_mclk(i_mclk), .o_wr(fwr), .o_rd(frd), .o_wdata(fwd),
    .i_rdata(frdata)
  );
  // 250 MHz clock
  initial
  begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  // expected flags byte: events high, bit 3 always zero
  function automatic rfc_byte_t fexp(input logic [3:0] e,
                                     input logic [2:0] c);
    return {e, 1'b0, c};
  endfunction : fexp
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // k cycles of random ticks (or none), counted as the live time
  task automatic run(input int k, input bit rnd);
    repeat (k)
    begin
      @(negedge i_mclk);
      n = $random(seed);
      tick = rnd & n[0];
      cnt = cnt + {31'h0, tick};
    end
    @(negedge i_mclk);
    tick = 1'b0;
  endtask : run
  // verdict and end of run
  task automatic conclude;
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  // hang guard
  initial
  begin
    #200000;
    miscompares++;
    conclude;
  end
  // main sequence
  initial
  begin
    seed = 29827;
    miscompares = 0;
    checks_done = 0;
    cnt = 32'h0;
    {i_arst_n, uwr, tick, ev, uwd} = '0;
    repeat (16) @(negedge i_mclk);
    chk(busy, 1'b0);
    chk(frdata, 8'h00);
    i_arst_n = 1'b1;
    host.get(rb);
    chk(rb, fexp(4'h0, 3'h0));
    // free running copy follows live time
    run(30, 1);
    run(4, 0);
    chk(ltime, cnt);
    chk(utime, cnt);
    // freeze without the write bit
    host.put(8'h01);
    run(4, 0);
    snap = cnt;
    run(40, 1);
    run(4, 0);
    chk(utime, snap);
    chk(ltime, cnt);
    host.get(rb);
    chk(rb, fexp(4'h0, 3'h1));
    // release freeze
    host.put(8'h00);
    run(4, 0);
    chk(utime, cnt);
    // user write under the write bit, then timed transfer
    host.put(8'h02);
    @(negedge i_mclk);
    uwr = 1'b1;
    uwd = $random(seed);
    v = uwd;
    @(negedge i_mclk);
    uwr = 1'b0;
    uwd = ~v;
    run(10, 1);
    run(4, 0);
    chk(utime, v);
    host.put(8'h00);
    n = 0;
    repeat (XC + 8)
    begin
      @(negedge i_mclk);
      n += busy;
      chk(utime, v);
    end
    chk(n, XC);
    chk(ltime, v);
    chk(utime, v);
    // write bit zero to zero starts nothing
    host.put(8'h00);
    run(2, 0);
    chk(busy, 1'b0);
    // event flags, cleared by read except osc fault
    @(negedge i_mclk);
    ev = 4'hf;
    @(negedge i_mclk);
    ev = 4'h0;
    host.get(rb);
    chk(rb, fexp(4'hf, 3'h0));
    host.get(rb);
    chk(rb, fexp(4'h1, 3'h0));
    // calibration set, osc fault cleared, bit 3 reads zero
    host.put(8'h0c);
    host.get(rb);
    chk(rb, fexp(4'h0, 3'h4));
    chk(cal, 1'b1);
    // random events in and after the read cycle; set wins over clear
    s = 4'h0;
    repeat (24)
    begin
      n = $random(seed);
      a = n[3:0];
      b = n[7:4];
      fork
        host.get(rb);
        begin
          @(negedge i_mclk);
          ev = a;
          @(negedge i_mclk);
          ev = b;
          @(negedge i_mclk);
          ev = 4'h0;
        end
      join
      chk(rb, fexp(s, 3'h4));
      s = {a[3:1] | b[3:1], s[0] | a[0] | b[0]};
      if (n[8])
      begin
        // osc fault cleared by a zero write, calibration kept
        host.put(8'h04);
        s[0] = 1'b0;
      end
    end
    // mid-run reset with both control bits set
    host.put(8'h03);
    @(negedge i_mclk);
    i_arst_n = 1'b0;
    cnt = 32'h0;
    repeat (2) @(negedge i_mclk);
    chk(busy, 1'b0);
    chk(cal, 1'b0);
    chk(ltime, 32'h0);
    i_arst_n = 1'b1;
    host.get(rb);
    chk(rb, fexp(4'h0, 3'h0));
    // copy runs freely again after reset
    run(20, 1);
    run(4, 0);
    chk(ltime, cnt);
    chk(utime, cnt);
    conclude;
  end
endmodule : test_rfc_top
